// ---- hdl/gesture_ctrl_pkg.sv ----
// constants for the gesture entry and exit control block
package gesture_ctrl_pkg;

    // ----------------------------------------------------------------
    // register map (word index on the plain register port)
    // ----------------------------------------------------------------
    localparam logic [3:0] entry_thresh_addr  = 4'h0;
    localparam logic [3:0] exit_thresh_addr   = 4'h1;
    localparam logic [3:0] exit_control_addr  = 4'h2;
    localparam logic [3:0] cycle_control_addr = 4'h3;
    localparam logic [3:0] status_addr        = 4'h4;
    localparam logic [3:0] control_addr       = 4'h5;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] entry_thresh_rst  = 8'h00;
    localparam logic [7:0] exit_thresh_rst   = 8'h00;
    localparam logic [7:0] exit_control_rst  = 8'h00;
    localparam logic [7:0] cycle_control_rst = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int mask_east_bit     = 2;
    localparam int mask_west_bit     = 3;
    localparam int mask_south_bit    = 4;
    localparam int mask_north_bit    = 5;
    localparam int exit_pers_lsb     = 0;
    localparam int enter_always_bit  = 7;
    localparam int gain_lsb          = 5;
    localparam int led_drive_lsb     = 3;
    localparam int wait_lsb          = 0;

    // ----------------------------------------------------------------
    // timing: wait steps in units of 100 us
    // ----------------------------------------------------------------
    localparam int clk_freq_hz       = 40000000;
    localparam int wait_unit_us      = 100;
    localparam int wait_unit_cycles  = clk_freq_hz / 1000000 * wait_unit_us;

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle    = 4'h1,
        st_detect  = 4'h2,
        st_wait    = 4'h4,
        st_entry   = 4'h8
    } gest_state_type;

endpackage

// ---- hdl/wait_rom.sv ----
// lookup of inter-cycle wait lengths in 100 us steps
`timescale 1ns/100ps
`default_nettype none
module wait_rom (
    // clock
    input  wire logic       ref_clk_i,
    // lookup
    input  wire logic [2:0] code_i,
    output logic      [8:0] steps_o
);
    always_ff @(posedge ref_clk_i) begin
        unique case (code_i)
            3'h0: steps_o <= 9'h000;
            3'h1: steps_o <= 9'h01C;
            3'h2: steps_o <= 9'h038;
            3'h3: steps_o <= 9'h054;
            3'h4: steps_o <= 9'h08C;
            3'h5: steps_o <= 9'h0E0;
            3'h6: steps_o <= 9'h134;
            3'h7: steps_o <= 9'h188;
        endcase
    end
endmodule
`default_nettype wire

// ---- hdl/gesture_entry_exit_control.sv ----
// gesture entry, exit filtering and cycle settings
`timescale 1ns/100ps
`default_nettype none

module gesture_entry_exit_control #(
    parameter int unsigned wait_unit_cycles = gesture_ctrl_pkg::wait_unit_cycles
) (
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [3:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    output logic      [7:0] reg_rdata_o,
    // engine inputs
    input  wire logic       prox_valid_i,
    input  wire logic [7:0] proximity_result_i,
    input  wire logic       dir_valid_i,
    input  wire logic [7:0] north_data_i,
    input  wire logic [7:0] south_data_i,
    input  wire logic [7:0] west_data_i,
    input  wire logic [7:0] east_data_i,
    // engine outputs
    output logic            gesture_active_o,
    output logic            detect_cycle_o,
    output logic            low_power_o,
    output logic      [3:0] gain_mult_o,
    output logic      [7:0] led_drive_level_o
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] pers_target(input logic [1:0] code);
        unique case (code)
            2'h0: pers_target = 3'h1;
            2'h1: pers_target = 3'h2;
            2'h2: pers_target = 3'h4;
            2'h3: pers_target = 3'h7;
        endcase
    endfunction

    function automatic logic below(input logic [7:0] data, input logic [7:0] th);
        below = (data < th);
    endfunction

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]                      entry_threshold_ff;
    logic [7:0]                      exit_threshold_ff;
    logic [7:0]                      gesture_exit_control_ff;
    logic [7:0]                      gesture_cycle_control_ff;
    logic                            gesture_run_flag_ff;
    gesture_ctrl_pkg::gest_state_type state_ff;
    logic [2:0]                      end_count_ff;
    logic [8:0]                      steps_left_ff;
    logic [$clog2(wait_unit_cycles+1)-1:0] unit_cnt_ff;
    logic                            unit_tick;
    logic [8:0]                      wait_steps;
    logic [3:0]                      exit_detector_mask;
    logic [1:0]                      exit_persistence;
    logic                            enter_always;
    logic [1:0]                      photodiode_gain;
    logic [1:0]                      led_drive_setting;
    logic [2:0]                      inter_cycle_wait;
    logic                            gesture_end;
    logic                            entry_ok;
    logic [2:0]                      nxt_end_count;
    logic                            leave_gesture;

    // ----------------------------------------------------------------
    // field views
    // ----------------------------------------------------------------
    assign exit_detector_mask = gesture_exit_control_ff[gesture_ctrl_pkg::mask_north_bit:
                                                        gesture_ctrl_pkg::mask_east_bit];
    assign exit_persistence   = gesture_exit_control_ff[gesture_ctrl_pkg::exit_pers_lsb +: 2];
    assign enter_always       = gesture_cycle_control_ff[gesture_ctrl_pkg::enter_always_bit];
    assign photodiode_gain    = gesture_cycle_control_ff[gesture_ctrl_pkg::gain_lsb +: 2];
    assign led_drive_setting  = gesture_cycle_control_ff[gesture_ctrl_pkg::led_drive_lsb +: 2];
    assign inter_cycle_wait   = gesture_cycle_control_ff[gesture_ctrl_pkg::wait_lsb +: 3];

    // ----------------------------------------------------------------
    // threshold registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            entry_threshold_ff <= gesture_ctrl_pkg::entry_thresh_rst;
        end else if (reg_wr_i && reg_addr_i == gesture_ctrl_pkg::entry_thresh_addr) begin
            entry_threshold_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            exit_threshold_ff <= gesture_ctrl_pkg::exit_thresh_rst;
        end else if (reg_wr_i && reg_addr_i == gesture_ctrl_pkg::exit_thresh_addr) begin
            exit_threshold_ff <= reg_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gesture_exit_control_ff <= gesture_ctrl_pkg::exit_control_rst;
        end else if (reg_wr_i && reg_addr_i == gesture_ctrl_pkg::exit_control_addr) begin
            gesture_exit_control_ff <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gesture_cycle_control_ff <= gesture_ctrl_pkg::cycle_control_rst;
        end else if (reg_wr_i && reg_addr_i == gesture_ctrl_pkg::cycle_control_addr) begin
            gesture_cycle_control_ff <= reg_wdata_i;
        end
    end

    // ----------------------------------------------------------------
    // run flag
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gesture_run_flag_ff <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == gesture_ctrl_pkg::control_addr) begin
            gesture_run_flag_ff <= reg_wdata_i[0];
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                gesture_ctrl_pkg::entry_thresh_addr:  reg_rdata_o <= entry_threshold_ff;
                gesture_ctrl_pkg::exit_thresh_addr:   reg_rdata_o <= exit_threshold_ff;
                gesture_ctrl_pkg::exit_control_addr:  reg_rdata_o <= gesture_exit_control_ff;
                gesture_ctrl_pkg::cycle_control_addr: reg_rdata_o <= gesture_cycle_control_ff;
                gesture_ctrl_pkg::status_addr:        reg_rdata_o <= {1'b0, end_count_ff,
                                                                      state_ff};
                gesture_ctrl_pkg::control_addr:       reg_rdata_o <= {7'h00, gesture_run_flag_ff};
                default:                              reg_rdata_o <= 8'h00;
            endcase
        end else begin
            reg_rdata_o <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // entry and end decisions
    // ----------------------------------------------------------------
    assign entry_ok = enter_always ||
                      (proximity_result_i >= entry_threshold_ff);

    // a masked detector cannot veto the end; all masked counts as no end
    always_comb begin
        gesture_end = (exit_threshold_ff != 8'h00) && (exit_detector_mask != 4'hF);
        if (!exit_detector_mask[0] && !below(east_data_i, exit_threshold_ff)) begin
            gesture_end = 1'b0;
        end
        if (!exit_detector_mask[1] && !below(west_data_i, exit_threshold_ff)) begin
            gesture_end = 1'b0;
        end
        if (!exit_detector_mask[2] && !below(south_data_i, exit_threshold_ff)) begin
            gesture_end = 1'b0;
        end
        if (!exit_detector_mask[3] && !below(north_data_i, exit_threshold_ff)) begin
            gesture_end = 1'b0;
        end
    end

    assign nxt_end_count = gesture_end ? end_count_ff + 3'h1 : 3'h0;

    assign leave_gesture = gesture_end &&
                           (nxt_end_count >= pers_target(exit_persistence));

    // ----------------------------------------------------------------
    // wait timing
    // ----------------------------------------------------------------
    wait_rom u_wait_rom (
        .ref_clk_i (ref_clk_i),
        .code_i    (inter_cycle_wait),
        .steps_o   (wait_steps)
    );

    // ----------------------------------------------------------------
    // unit timer
    // ----------------------------------------------------------------
    assign unit_tick = (unit_cnt_ff == ($bits(unit_cnt_ff))'(wait_unit_cycles - 1));

    always_ff @(posedge ref_clk_i) begin
        if (rst_i || state_ff != gesture_ctrl_pkg::st_wait || unit_tick) begin
            unit_cnt_ff <= '0;
        end else begin
            unit_cnt_ff <= unit_cnt_ff + 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // gesture state machine
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff <= gesture_ctrl_pkg::st_idle;
        end else if (!gesture_run_flag_ff) begin
            state_ff <= gesture_ctrl_pkg::st_idle;
        end else begin
            unique case (state_ff)
                gesture_ctrl_pkg::st_idle: begin
                    if (prox_valid_i && entry_ok) begin
                        state_ff <= gesture_ctrl_pkg::st_entry;
                    end
                end
                gesture_ctrl_pkg::st_entry: begin
                    state_ff <= gesture_ctrl_pkg::st_detect;
                end
                gesture_ctrl_pkg::st_detect: begin
                    if (dir_valid_i && leave_gesture) begin
                        state_ff <= gesture_ctrl_pkg::st_idle;
                    end else if (dir_valid_i) begin
                        state_ff <= gesture_ctrl_pkg::st_wait;
                    end
                end
                gesture_ctrl_pkg::st_wait: begin
                    if (steps_left_ff == 9'h000) begin
                        state_ff <= gesture_ctrl_pkg::st_detect;
                    end
                end
                default: state_ff <= gesture_ctrl_pkg::st_idle;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // consecutive end counter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !gesture_run_flag_ff) begin
            end_count_ff <= 3'h0;
        end else if (state_ff == gesture_ctrl_pkg::st_idle && prox_valid_i && entry_ok) begin
            end_count_ff <= 3'h0;
        end else if (state_ff == gesture_ctrl_pkg::st_detect && dir_valid_i) begin
            end_count_ff <= nxt_end_count;
        end
    end

    // ----------------------------------------------------------------
    // wait step counter
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            steps_left_ff <= 9'h000;
        end else if (gesture_run_flag_ff) begin
            if (state_ff == gesture_ctrl_pkg::st_detect && dir_valid_i && !leave_gesture) begin
                steps_left_ff <= wait_steps;
            end else if (state_ff == gesture_ctrl_pkg::st_wait && unit_tick &&
                         steps_left_ff != 9'h000) begin
                steps_left_ff <= steps_left_ff - 9'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // state outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gesture_active_o <= 1'b0;
        end else begin
            gesture_active_o <= gesture_run_flag_ff && (state_ff != gesture_ctrl_pkg::st_idle);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            detect_cycle_o <= 1'b0;
        end else begin
            detect_cycle_o <= gesture_run_flag_ff && (state_ff == gesture_ctrl_pkg::st_detect);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            low_power_o <= 1'b0;
        end else begin
            low_power_o <= gesture_run_flag_ff && (state_ff == gesture_ctrl_pkg::st_wait);
        end
    end

    // ----------------------------------------------------------------
    // gain and drive outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gain_mult_o <= 4'h1;
        end else begin
            gain_mult_o <= 4'h1 << photodiode_gain;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            led_drive_level_o <= 8'hFF;
        end else begin
            led_drive_level_o <= 8'hFF >> led_drive_setting;
        end
    end

endmodule
`default_nettype wire

// ---- sim/gesture_ctrl_chk.sv ----
// port checker for the gesture entry and exit control block
`timescale 1ns/100ps
`default_nettype none
module gesture_ctrl_chk #(
    parameter int unsigned wait_unit_cycles = 4000
) (
    // clock, reset, register port
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // engine
    input wire logic       prox_valid_i,
    input wire logic [7:0] proximity_result_i,
    input wire logic       dir_valid_i,
    input wire logic [7:0] north_data_i,
    input wire logic [7:0] south_data_i,
    input wire logic [7:0] west_data_i,
    input wire logic [7:0] east_data_i,
    input wire logic       gesture_active_o,
    input wire logic       detect_cycle_o,
    input wire logic       low_power_o,
    input wire logic [3:0] gain_mult_o,
    input wire logic [7:0] led_drive_level_o
);
    localparam int wait_max = 392 * wait_unit_cycles;
    int lp_cnt_ff;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // ---------------------------------------------------------------
    // wait length counter
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !low_power_o) begin
            lp_cnt_ff <= 0;
        end else begin
            lp_cnt_ff <= lp_cnt_ff + 1;
        end
    end
    a_rdata_one_cycle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("read data outside the answer cycle");
    a_gain_field: assert property (reg_wr_i && reg_addr_i == 4'h3 |-> ##2
        gain_mult_o == (4'h1 << (($past(reg_wdata_i, 2) >> 5) & 8'h03)))
        else $error("gain does not follow its field");
    a_drive_field: assert property (reg_wr_i && reg_addr_i == 4'h3 |-> ##2
        led_drive_level_o == (8'hFF >> (($past(reg_wdata_i, 2) >> 3) & 8'h03)))
        else $error("led drive does not follow its field");
    a_reset_quiet: assert property (disable iff (1'b0) rst_i [*2] |=>
        !gesture_active_o && !detect_cycle_o && !low_power_o && gain_mult_o == 4'h1)
        else $error("outputs not quiet in reset");
    a_phase_excl: assert property (!(detect_cycle_o && low_power_o))
        else $error("detect and low power together");
    a_phase_in_gesture: assert property (detect_cycle_o || low_power_o |-> gesture_active_o)
        else $error("phase outside gesture");
    a_entry_cause: assert property ($rose(gesture_active_o) |-> $past(prox_valid_i, 2))
        else $error("entry without proximity result");
    a_wait_cause: assert property ($rose(low_power_o) |-> $past(dir_valid_i, 2))
        else $error("wait without detection cycle end");
    a_wait_bound: assert property (low_power_o |-> lp_cnt_ff <= wait_max)
        else $error("wait longer than largest code");
    a_exit_cause: assert property ($fell(gesture_active_o) |-> $past(dir_valid_i, 2)
        || $past(reg_wr_i, 2) || $past(reg_wr_i, 3))
        else $error("exit without cause");
endmodule
bind gesture_entry_exit_control gesture_ctrl_chk #(.wait_unit_cycles(wait_unit_cycles)) chk_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .prox_valid_i(prox_valid_i), .proximity_result_i(proximity_result_i),
    .dir_valid_i(dir_valid_i), .north_data_i(north_data_i), .south_data_i(south_data_i),
    .west_data_i(west_data_i), .east_data_i(east_data_i), .gesture_active_o(gesture_active_o),
    .detect_cycle_o(detect_cycle_o), .low_power_o(low_power_o), .gain_mult_o(gain_mult_o),
    .led_drive_level_o(led_drive_level_o));
`default_nettype wire

// ---- sim/tb.sv ----
// testbench for the gesture entry and exit control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic       ref_clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       prox_valid_i = 1'b0, dir_valid_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, proximity_result_i = 8'h00;
    logic [7:0] north_data_i = 8'h00, south_data_i = 8'h00, west_data_i = 8'h00;
    logic [7:0] east_data_i = 8'h00, reg_rdata_o, led_drive_level_o;
    logic [3:0] gain_mult_o;
    logic       gesture_active_o, detect_cycle_o, low_power_o;
    int         mismatches = 0, comparisons = 0, run = 0, last = 0;
    localparam int unit = 4;
    localparam int steps [8] = '{0, 28, 56, 84, 140, 224, 308, 392};
    localparam int need [4] = '{1, 2, 4, 7};
    localparam logic [3:0] mk [7] = '{4'h1, 4'h0, 4'h2, 4'h4, 4'h8, 4'h6, 4'hF};
    localparam logic [3:0] hi [7] = '{4'h1, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'h0};
    localparam logic st [7] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    gesture_entry_exit_control #(.wait_unit_cycles(unit)) dut (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
        .prox_valid_i(prox_valid_i), .proximity_result_i(proximity_result_i),
        .dir_valid_i(dir_valid_i), .north_data_i(north_data_i), .south_data_i(south_data_i),
        .west_data_i(west_data_i), .east_data_i(east_data_i), .gesture_active_o(gesture_active_o),
        .detect_cycle_o(detect_cycle_o), .low_power_o(low_power_o), .gain_mult_o(gain_mult_o),
        .led_drive_level_o(led_drive_level_o));
    always #12.5 ref_clk_i = ~ref_clk_i;
    // ---------------------------------------------------------------
    // low power span measurement
    // ---------------------------------------------------------------
    always @(posedge ref_clk_i) begin
        if (low_power_o === 1'b1) begin
            run <= run + 1;
        end else if (run != 0) begin
            last <= run;
            run <= 0;
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask
    task automatic prox(input logic [7:0] v);
        @(posedge ref_clk_i);
        proximity_result_i <= v;
        prox_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        prox_valid_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    // bit set in h puts that detector (n, s, w, e) above the exit threshold
    task automatic dir(input logic [3:0] h);
        int k;
        k = 0;
        while (detect_cycle_o !== 1'b1 && k < 4000) begin
            @(posedge ref_clk_i);
            k++;
        end
        if (k >= 4000) chk(8'h00, 8'h01);
        @(posedge ref_clk_i);
        north_data_i <= h[3] ? 8'h40 : 8'h00;
        south_data_i <= h[2] ? 8'h40 : 8'h00;
        west_data_i <= h[1] ? 8'h40 : 8'h00;
        east_data_i <= h[0] ? 8'h40 : 8'h00;
        dir_valid_i <= 1'b1;
        @(posedge ref_clk_i);
        dir_valid_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
    endtask
    task automatic enter();
        wr(4'h5, 8'h00);
        wr(4'h5, 8'h01);
        prox(8'h00);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        give_verdict();
    end
    initial begin
        int w;
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rd(4'(i), 8'h00);
        rd(4'hF, 8'h00);
        wr(4'h4, 8'hFF);
        rd(4'h4, 8'h01);
        chk({4'h0, gain_mult_o}, 8'h01);
        chk(led_drive_level_o, 8'hFF);
        $display("test reset done");
        for (int g = 0; g < 4; g++) begin
            wr(4'h3, 8'(g * 8'h28));
            repeat (3) @(posedge ref_clk_i);
            chk({4'h0, gain_mult_o}, 8'h01 << g);
            chk(led_drive_level_o, 8'hFF >> g);
            rd(4'h3, 8'(g * 8'h28));
        end
        $display("test fields done");
        wr(4'h0, 8'h40);
        wr(4'h1, 8'h20);
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h01);
        prox(8'h3F);
        rd(4'h4, 8'h01);
        prox(8'h40);
        rd(4'h4, 8'h02);
        wr(4'h3, 8'h80);
        $display("test entry done");
        foreach (need[p]) begin
            wr(4'h2, 8'(p));
            enter();
            chk({7'h0, gesture_active_o}, 8'h01);
            for (int k = 1; k < need[p]; k++) dir(4'h0);
            rd(4'h4, {1'b0, 3'(need[p] - 1), 4'h2});
            dir(4'hF);
            for (int k = 1; k < need[p]; k++) dir(4'h0);
            chk({7'h0, gesture_active_o}, 8'h01);
            dir(4'h0);
            chk({7'h0, gesture_active_o}, 8'h00);
        end
        $display("test persistence done");
        foreach (mk[i]) begin
            wr(4'h2, {2'b00, mk[i], 2'b00});
            enter();
            dir(hi[i]);
            chk({7'h0, gesture_active_o}, {7'h0, st[i]});
        end
        wr(4'h1, 8'h00);
        wr(4'h2, 8'h00);
        enter();
        dir(4'h0);
        chk({7'h0, gesture_active_o}, 8'h01);
        wr(4'h5, 8'h00);
        repeat (4) @(posedge ref_clk_i);
        chk({7'h0, gesture_active_o}, 8'h00);
        $display("test masks done");
        wr(4'h1, 8'h20);
        enter();
        foreach (steps[c]) begin
            w = (steps[c] == 0) ? 1 : steps[c] * unit;
            wr(4'h3, 8'h80 | 8'(c));
            dir(4'hF);
            dir(4'hF);
            chk({7'h0, last >= w && last <= w + 1}, 8'h01);
        end
        $display("test wait done");
        give_verdict();
    end
endmodule
`default_nettype wire
